// File: logic/opt_params.svh
// Constants for the output pulse timer: offsets, codes, field positions
`ifndef OPT_PARAMS_SVH
`define OPT_PARAMS_SVH

`define OPT_ADDR_W      3
`define OPT_DATA_W      16
`define OPT_CTRL_W      9
`define OPT_SYNC_W      9
`define OPT_SYNC_CLK_LSB 5

// Register offsets (word index)
`define OPT_OFF_CTRL    3'h0
`define OPT_OFF_ENABLE  3'h1
`define OPT_OFF_COUNT   3'h2
`define OPT_OFF_RELOAD  3'h3
`define OPT_OFF_STATUS  3'h4
`define OPT_OFF_MASK    3'h5

// Field positions and codes
`define OPT_EN_BIT      0
`define OPT_ENS_BUS_BIT 2
`define OPT_MODE_CONT_BIT 1
`define OPT_MODE_SINGLE 2'h0
`define OPT_MODE_DELAY  2'h1
`define OPT_EDGE_OFF    2'h0
`define OPT_EDGE_RISE   2'h1
`define OPT_EDGE_FALL   2'h2
`define OPT_EDGE_BOTH   2'h3

// Reset values and counter limits
`define OPT_CTRL_RST    9'h000
`define OPT_DATA_ZERO   16'h0000
`define OPT_CNT_MAX     16'hffff
`define OPT_CNT_STEP    16'h0001

`endif

// File: logic/opt_pkg.sv
// Types shared by the output pulse timer files
`default_nettype none
`include "opt_params.svh"
package opt_pkg;

  typedef logic [`OPT_DATA_W-1:0] opt_data_type;

  // Control word, high field first
  typedef struct packed
  {
    logic [1:0] edgeSel;
    logic [1:0] count_clock_select;
    logic [2:0] enable_source_select;
    logic [1:0] channel_mode_field;
  } opt_ctrl_type;

  // Plain register port from the master
  typedef struct packed
  {
    logic [`OPT_ADDR_W-1:0] addr;
    opt_data_type           wdata;
    logic                   wr;
    logic                   rd;
  } opt_bus_type;

  typedef enum logic [3:0]
  {
    OPT_IDLE  = 4'b0001,
    OPT_ARMED = 4'b0010,
    OPT_DELAY = 4'b0100,
    OPT_RUN   = 4'b1000
  } opt_state_type;

endpackage
`default_nettype wire

// File: logic/opt_sync.sv
// Two-flop synchroniser for a group of pins
`timescale 1ns/1ns
`default_nettype none
module opt_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             clkEn,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      meta   <= '0;
      synced <= '0;
    end
    else if (clkEn)
    begin
      meta   <= pinIn;
      synced <= meta;
    end
  end

endmodule
`default_nettype wire

// File: logic/opt_edge.sv
// Edge detector with selectable polarity on a synchronised level
`timescale 1ns/1ns
`default_nettype none
`include "opt_params.svh"
module opt_edge (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       clkEn,
  input  wire logic [1:0] sel,
  input  wire logic       level,
  output logic            pulse
);

  logic prev;

  // Last level, frozen with the clock enable
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      prev <= 1'b0;
    else if (clkEn)
      prev <= level;
  end

  // Polarity choice; off means no start from this source
  always_comb
  begin
    case (sel)
      `OPT_EDGE_RISE: pulse = level & ~prev;
      `OPT_EDGE_FALL: pulse = ~level & prev;
      `OPT_EDGE_BOTH: pulse = level ^ prev;
      default:        pulse = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

// File: logic/opt_output_pulse_timer.sv
// Output pulse timer channel: registers, counter, output flop, interrupt
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "opt_params.svh"
module opt_output_pulse_timer (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic                 clkEn,
  input  wire opt_pkg::opt_bus_type regBus,
  output opt_pkg::opt_data_type     rdData,
  input  wire logic [3:0]           clockBus,
  input  wire logic [3:0]           eventBus,
  input  wire logic                 external_enable_input,
  output logic                      timerOut,
  output logic                      irqLevel,
  output logic                      irqPulse
);
  import opt_pkg::*;

  opt_ctrl_type                 ctrl;
  opt_state_type                state;
  opt_data_type                 count;
  opt_data_type                 reload;
  logic                         status;
  logic                         mask;
  logic [`OPT_SYNC_W-1:0]       syncBits;
  logic                         clkLevel;
  logic                         srcLevel;
  logic                         countTick;
  logic                         extEdge;
  logic                         wrCtrl;
  logic                         wrEnable;
  logic                         wrCount;
  logic                         wrReload;
  logic                         wrStatus;
  logic                         wrMask;
  logic                         startSw;
  logic                         stopSw;
  logic                         runTick;
  logic                         armTick;
  logic                         running;
  logic                         underflow;
  logic                         delayedMode;
  logic                         contMode;
  logic                         ctrlFresh;

  // Address hit, shared by all write decodes
  function automatic logic hit(input logic [`OPT_ADDR_W-1:0] addr,
                               input logic [`OPT_ADDR_W-1:0] off);
    return addr == off;
  endfunction
  // Mode decode: 1X continuous regardless of low bit
  function automatic logic isContinuous(input logic [1:0] mode);
    return mode[`OPT_MODE_CONT_BIT];
  endfunction
  function automatic logic isDelayed(input logic [1:0] mode);
    return mode == `OPT_MODE_DELAY;
  endfunction
  // Enable source: pin for 0XX, event bus by low bits otherwise
  function automatic logic pickSource(input logic [2:0] ens,
                                      input logic       pin,
                                      input logic [3:0] ev);
    return ens[`OPT_ENS_BUS_BIT] ? ev[ens[1:0]] : pin;
  endfunction

  // All outside levels cross in through two flops
  opt_sync #(
    .WIDTH (`OPT_SYNC_W)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .clkEn    (clkEn),
    .pinIn    ({clockBus, eventBus, external_enable_input}),
    .synced   (syncBits)
  );

  // Count clock and enable source selection
  always_comb
  begin
    clkLevel = syncBits[`OPT_SYNC_CLK_LSB + ctrl.count_clock_select];
    srcLevel = pickSource(ctrl.enable_source_select, syncBits[0],
                          syncBits[4:1]);
  end

  // Count clock rising edge gives one tick per count clock
  opt_edge u_tick (
    .core_clk (core_clk),
    .rst      (rst),
    .clkEn    (clkEn),
    .sel      (`OPT_EDGE_RISE),
    .level    (clkLevel),
    .pulse    (countTick)
  );

  // External start edge with software-chosen polarity
  opt_edge u_trig (
    .core_clk (core_clk),
    .rst      (rst),
    .clkEn    (clkEn),
    .sel      (ctrl.edgeSel),
    .level    (srcLevel),
    .pulse    (extEdge)
  );

  // Write decodes
  always_comb
  begin
    wrCtrl   = regBus.wr & hit(regBus.addr, `OPT_OFF_CTRL);
    wrEnable = regBus.wr & hit(regBus.addr, `OPT_OFF_ENABLE);
    wrCount  = regBus.wr & hit(regBus.addr, `OPT_OFF_COUNT);
    wrReload = regBus.wr & hit(regBus.addr, `OPT_OFF_RELOAD);
    wrStatus = regBus.wr & hit(regBus.addr, `OPT_OFF_STATUS);
    wrMask   = regBus.wr & hit(regBus.addr, `OPT_OFF_MASK);
  end

  // Start and stop requests, and the count-clock qualified events
  always_comb
  begin
    startSw     = wrEnable & regBus.wdata[`OPT_EN_BIT];
    stopSw      = wrEnable & ~regBus.wdata[`OPT_EN_BIT];
    delayedMode = isDelayed(ctrl.channel_mode_field);
    contMode    = isContinuous(ctrl.channel_mode_field);
    running     = (state == OPT_DELAY) | (state == OPT_RUN);
    runTick     = clkEn & countTick & ~stopSw;
    armTick     = runTick & (state == OPT_ARMED);
    underflow   = runTick & running & (count == `OPT_DATA_ZERO);
  end

  // Control word; a mode change while running is software's hazard
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl      <= `OPT_CTRL_RST;
      ctrlFresh <= 1'b0;
    end
    else if (clkEn)
    begin
      ctrlFresh <= wrCtrl; // Source switch may fake one edge
      if (wrCtrl)
        ctrl <= regBus.wdata[`OPT_CTRL_W-1:0];
    end
  end

  // Reload register, written by software only
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      reload <= `OPT_DATA_ZERO;
    else if (clkEn && wrReload)
      reload <= regBus.wdata;
  end

  // Sequencer: delay or run picked at the first count tick after the start; continuous bit read at each underflow in run
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      state <= OPT_IDLE;
    else if (clkEn)
    begin
      if (stopSw)
        state <= OPT_IDLE;
      else
      begin
        case (state)
          OPT_IDLE:
            if (startSw || (extEdge && !ctrlFresh))
              state <= OPT_ARMED;
          OPT_ARMED:
            if (armTick)
              state <= delayedMode ? OPT_DELAY : OPT_RUN;
          OPT_DELAY:
            if (underflow)
              state <= OPT_RUN;
          OPT_RUN:
            if (underflow && !contMode)
              state <= OPT_IDLE;
          default:
            state <= OPT_IDLE;
        endcase
      end
    end
  end

  // Down-counter; a software write wins over counting
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      count <= `OPT_DATA_ZERO;
    else if (clkEn)
    begin
      if (wrCount)
        count <= regBus.wdata;
      else if (armTick && !delayedMode && !contMode)
        count <= reload;
      else if (underflow)
      begin
        // Halted single shot rests at the wrapped value
        if (state == OPT_DELAY || contMode)
          count <= reload;
        else
          count <= `OPT_CNT_MAX;
      end
      else if (runTick && running)
        count <= count - `OPT_CNT_STEP;
    end
  end

  // Output flop: start toggle except delayed mode, toggle per underflow
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      timerOut <= 1'b0;
    else if (clkEn && ((armTick && !delayedMode) || underflow))
      timerOut <= ~timerOut;
  end

  // Sticky underflow flag; a new underflow beats a same-cycle clear
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      status <= 1'b0;
    else if (clkEn)
      status <= (status & ~(wrStatus & regBus.wdata[`OPT_EN_BIT]))
                | underflow;
  end

  // Interrupt mask, one means enabled
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      mask <= 1'b0;
    else if (clkEn && wrMask)
      mask <= regBus.wdata[`OPT_EN_BIT];
  end

  // Level request follows the masked flag one cycle late
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      irqLevel <= 1'b0;
    else if (clkEn)
      irqLevel <= status & mask;
  end

  // Raw request pulse to the interrupt controller, never masked
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      irqPulse <= 1'b0;
    else if (clkEn)
      irqPulse <= underflow;
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rdData <= `OPT_DATA_ZERO;
    else if (clkEn)
    begin
      if (regBus.rd)
      begin
        case (regBus.addr)
          `OPT_OFF_CTRL:   rdData <= opt_data_type'(ctrl);
          `OPT_OFF_ENABLE: rdData <= opt_data_type'(state != OPT_IDLE);
          `OPT_OFF_COUNT:  rdData <= count;
          `OPT_OFF_RELOAD: rdData <= reload;
          `OPT_OFF_STATUS: rdData <= opt_data_type'(status);
          `OPT_OFF_MASK:   rdData <= opt_data_type'(mask);
          default:         rdData <= `OPT_DATA_ZERO;
        endcase
      end
      else
        rdData <= `OPT_DATA_ZERO;
    end
  end

  // Checks on the design's own behaviour
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence s_underflow;
    underflow;
  endsequence
  sequence s_reloaded;
    (count == $past(reload)) && (state == OPT_RUN);
  endsequence
  property p_toggle_on_underflow;
    s_underflow |=> timerOut != $past(timerOut);
  endproperty
  a_toggle_on_underflow: assert property (p_toggle_on_underflow)
    else $error("output did not toggle at underflow");
  property p_single_halts;
    s_underflow and (state == OPT_RUN) and !contMode |=> state == OPT_IDLE;
  endproperty
  a_single_halts: assert property (p_single_halts)
    else $error("single shot did not halt at underflow");
  property p_delay_reload;
    s_underflow and (state == OPT_DELAY) and !wrCount |=> s_reloaded;
  endproperty
  a_delay_reload: assert property (p_delay_reload)
    else $error("first delayed underflow did not reload");
  property p_cont_repeats;
    s_underflow and (state == OPT_RUN) and contMode and !wrCount
      |=> (state == OPT_RUN) && (count == $past(reload));
  endproperty
  a_cont_repeats: assert property (p_cont_repeats)
    else $error("continuous mode did not reload and keep running");
  property p_request_pulse;
    s_underflow |=> irqPulse && status ##1 !irqPulse || $past(underflow);
  endproperty
  a_request_pulse: assert property (p_request_pulse)
    else $error("underflow request pulse wrong");
  property p_start_waits_tick;
    (state == OPT_ARMED) && !countTick && clkEn && !stopSw
      |=> (state == OPT_ARMED) && timerOut == $past(timerOut);
  endproperty
  a_start_waits_tick: assert property (p_start_waits_tick)
    else $error("start taken without a count clock edge");
  property p_decrement;
    runTick && running && (count != `OPT_DATA_ZERO) && !wrCount
      |=> count == $past(count) - `OPT_CNT_STEP;
  endproperty
  a_decrement: assert property (p_decrement)
    else $error("counter did not step down by one");
  property p_cont_decode;
    armTick && ctrl.channel_mode_field[`OPT_MODE_CONT_BIT]
      |=> state == OPT_RUN;
  endproperty
  a_cont_decode: assert property (p_cont_decode)
    else $error("mode 1X not decoded as continuous");
  property p_stop_write;
    clkEn && stopSw |=> state == OPT_IDLE;
  endproperty
  a_stop_write: assert property (p_stop_write)
    else $error("enable write of zero did not stop the channel");

endmodule
`default_nettype wire

// File: dv/opt_partner.sv
// Model of the output pin and interrupt controller beside the timer
`timescale 1ns/1ns
`default_nettype none
module opt_partner (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        timerOut,
  input  wire logic        irqPulse,
  output logic      [15:0] irqCount,
  output logic      [15:0] edgeCount
);
  logic pinLast;

  // Controller takes one request per pulse cycle, mask plays no part
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      irqCount <= 16'h0000;
    else if (irqPulse)
      irqCount <= irqCount + 16'h0001;
  end

  // Pin load counts every transition, so glitches between checks show
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pinLast   <= 1'b0;
      edgeCount <= 16'h0000;
    end
    else
    begin
      pinLast <= timerOut;
      if (pinLast != timerOut)
        edgeCount <= edgeCount + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// File: dv/tb.sv
// Self-checking bench for the output pulse timer channel
`timescale 1ns/1ns
`default_nettype none
`include "opt_params.svh"
module tb;
  import opt_pkg::*;
  logic         core_clk = 1'b0;
  logic         rst      = 1'b1;
  logic         clkEn    = 1'b1;
  opt_bus_type  regBus   = '0;
  opt_data_type rdData;
  logic [3:0]   clockBus = 4'h0;
  logic [4:0]   lines    = 5'h00;
  logic         timerOut;
  logic         irqLevel;
  logic         irqPulse;
  logic [15:0]  irqCount;
  logic [15:0]  edgeCount;
  logic         outExp   = 1'b0;
  logic [1:0]   cks      = 2'h0;
  int           miscompares = 0;
  int           tests_run   = 0;
  int           cycles = 0;
  int           irqExp = 0;
  int           edgeExp = 0;

  opt_output_pulse_timer i_dut (
    .core_clk(core_clk), .rst(rst), .clkEn(clkEn), .regBus(regBus),
    .rdData(rdData), .clockBus(clockBus), .eventBus(lines[3:0]),
    .external_enable_input(lines[4]), .timerOut(timerOut),
    .irqLevel(irqLevel), .irqPulse(irqPulse));

  opt_partner i_far (
    .core_clk(core_clk), .rst(rst), .timerOut(timerOut),
    .irqPulse(irqPulse), .irqCount(irqCount), .edgeCount(edgeCount));

  // Free-running 125 MHz clock
  always #4 core_clk = ~core_clk;

  // Hang guard, far above the under two thousand cycles the tests need
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compares=%0d mismatches=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Bus cycles: one-cycle strobes, read data in the following cycle
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regBus.addr  <= a;
    regBus.wdata <= d;
    regBus.wr    <= 1'b1;
    @(posedge core_clk);
    regBus.wr    <= 1'b0;
  endtask

  task automatic rdChk(input logic [2:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    regBus.addr <= a;
    regBus.rd   <= 1'b1;
    @(posedge core_clk);
    regBus.rd   <= 1'b0;
    #1;
    check(rdData, exp);
  endtask

  // One count clock; unselected buses get noise to prove selection
  task automatic tick();
    @(posedge core_clk);
    clockBus <= 4'($urandom) | (4'h1 << cks);
    repeat (6) @(posedge core_clk);
    clockBus <= 4'($urandom) & ~(4'h1 << cks);
    repeat (4) @(posedge core_clk);
    #1;
  endtask

  // Does tick t (0 = first after start) flip the output pin
  function automatic bit isTog(int m, int c, int r, int t);
    if (m == 0)
      return t == 0 || t == r + 1;
    if (m == 1)
      return t == c + 1 || t == c + r + 2;
    return t == 0 || (t > c && (t - c - 1) % (r + 1) == 0);
  endfunction

  // Start flips are not underflows
  function automatic bit isUnd(int m, int c, int r, int t);
    return isTog(m, c, r, t) && (t != 0 || m == 1);
  endfunction

  task automatic runMode(input logic [1:0] mode, input int c, input int r,
                         input int n);
    int           m;
    bit           und;
    logic         maskOn;
    opt_ctrl_type ct;
    m = mode[1] ? 2 : int'(mode);
    und = 1'b0;
    maskOn = 1'($urandom);
    cks = 2'($urandom);
    ct = '{2'h0, cks, 3'h0, mode};
    @(posedge core_clk);
    clockBus <= 4'h0;
    wr(`OPT_OFF_MASK, {15'h0, maskOn});
    wr(`OPT_OFF_CTRL, {7'h0, ct});
    wr(`OPT_OFF_COUNT, 16'(c));
    wr(`OPT_OFF_RELOAD, 16'(r));
    wr(`OPT_OFF_ENABLE, 16'h0001);
    #1;
    check({15'h0, timerOut}, {15'h0, outExp});
    rdChk(`OPT_OFF_ENABLE, 16'h0001);
    for (int k = 0; k < n; k++)
    begin
      // Second start while running must be ignored
      if (m == 2 && k == 2)
        wr(`OPT_OFF_ENABLE, 16'h0001);
      tick();
      if (isTog(m, c, r, k))
      begin
        outExp = ~outExp;
        edgeExp++;
      end
      if (isUnd(m, c, r, k))
      begin
        irqExp++;
        und = 1'b1;
      end
      check({15'h0, timerOut}, {15'h0, outExp});
      check(irqCount, 16'(irqExp));
    end
    if (m == 2)
    begin
      wr(`OPT_OFF_ENABLE, 16'h0000);
      tick();
      check({15'h0, timerOut}, {15'h0, outExp});
    end
    rdChk(`OPT_OFF_ENABLE, 16'h0000);
    if (m != 2)
      rdChk(`OPT_OFF_COUNT, `OPT_CNT_MAX);
    rdChk(`OPT_OFF_STATUS, {15'h0, und});
    check({15'h0, irqLevel}, {15'h0, und & maskOn});
    wr(`OPT_OFF_STATUS, 16'h0001);
    repeat (2) @(posedge core_clk);
    #1;
    check({15'h0, irqLevel}, 16'h0000);
    check(edgeCount, 16'(edgeExp));
    $display("test mode %0d c=%0d r=%0d done", m, c, r);
  endtask

  // Start from pin or event bus on a chosen edge, after a decoy edge
  task automatic ext(input int i);
    int           ln;
    logic [1:0]   eg;
    opt_ctrl_type ct;
    ln = i < 2 ? 4 : i - 2;
    eg = 2'(i % 3 + 1);
    ct = '{eg, cks, i < 2 ? {1'b0, 2'($urandom)} : 3'(2 + i),
           `OPT_MODE_SINGLE};
    wr(`OPT_OFF_CTRL, 16'h0000);
    @(posedge core_clk);
    if (eg != `OPT_EDGE_BOTH)
      lines[ln] <= (eg == `OPT_EDGE_FALL);
    repeat (4) @(posedge core_clk);
    wr(`OPT_OFF_RELOAD, 16'h0000);
    wr(`OPT_OFF_CTRL, {7'h0, ct});
    @(posedge core_clk);
    lines[(ln + 1) % 5] <= ~lines[(ln + 1) % 5];
    repeat (5) @(posedge core_clk);
    tick();
    check({15'h0, timerOut}, {15'h0, outExp});
    @(posedge core_clk);
    lines[ln] <= ~lines[ln];
    repeat (5) @(posedge core_clk);
    rdChk(`OPT_OFF_ENABLE, 16'h0001);
    repeat (2)
    begin
      tick();
      outExp = ~outExp;
      edgeExp++;
      check({15'h0, timerOut}, {15'h0, outExp});
    end
    irqExp++;
    check(irqCount, 16'(irqExp));
    rdChk(`OPT_OFF_ENABLE, 16'h0000);
    wr(`OPT_OFF_STATUS, 16'h0001);
    $display("test external start %0d done", i);
  endtask

  // Main sequence
  initial
  begin
    logic [15:0] v;
    void'($urandom(32'haa8caa80));
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    check({13'h0, timerOut, irqLevel, irqPulse}, 16'h0000);
    for (int a = 0; a < 8; a++)
      rdChk(3'(a), 16'h0000);
    wr(3'h6, 16'hffff);
    rdChk(3'h6, 16'h0000);
    v = 16'($urandom);
    wr(`OPT_OFF_CTRL, v);
    rdChk(`OPT_OFF_CTRL, v & 16'h01ff);
    wr(`OPT_OFF_CTRL, 16'h0000);
    wr(`OPT_OFF_RELOAD, v);
    rdChk(`OPT_OFF_RELOAD, v);
    // Clock enable low must swallow a write
    @(posedge core_clk);
    clkEn <= 1'b0;
    wr(`OPT_OFF_RELOAD, ~v);
    clkEn <= 1'b1;
    rdChk(`OPT_OFF_RELOAD, v);
    $display("test registers done");
    for (int j = 0; j < 4; j++)
    begin
      v = j == 0 ? 16'h0 : 16'($urandom_range(1, 6));
      runMode(`OPT_MODE_SINGLE, $urandom % 9, int'(v), int'(v) + 3);
    end
    for (int j = 0; j < 3; j++)
    begin
      v = j == 0 ? 16'h0 : 16'($urandom_range(1, 4));
      runMode(`OPT_MODE_DELAY, int'(v), j, int'(v) + j + 4);
    end
    runMode(2'h2, 0, 0, 6);
    runMode(2'h3, $urandom_range(1, 3), $urandom_range(1, 3), 12);
    for (int i = 0; i < 6; i++)
      ext(i);
    stop_test();
  end
endmodule
`default_nettype wire
